// File: gpx_pkg.sv
// Constants, register map and shared types of the multi-port GPIO block.
`default_nettype none

package gpx_pkg;

  // --------------------
  // Sizes
  // --------------------
  localparam int unsigned NPORT = 8;
  localparam int unsigned PW = 31;
  localparam int unsigned NPINT = 8;
  localparam int unsigned NGRP = 2;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned NIRQ = NPINT + NGRP;

  // --------------------
  // Register map, byte offsets
  // --------------------
  localparam logic [1:0] AREA_PORT = 2'h0;
  localparam logic [1:0] AREA_PINT = 2'h1;
  localparam logic [1:0] AREA_GRP = 2'h2;
  localparam logic [1:0] AREA_IRQ = 2'h3;
  // Offsets inside one port block; port p sits at p * 0x20.
  localparam logic [4:0] OFS_DIR = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_PIN = 5'h08;
  localparam logic [4:0] OFS_MPIN = 5'h0C;
  localparam logic [4:0] OFS_SET = 5'h10;
  localparam logic [4:0] OFS_CLR = 5'h14;
  localparam logic [4:0] OFS_PULL = 5'h18;
  localparam logic [4:0] OFS_OUT = 5'h1C;
  // Pin interrupt area at 0x100: selectors at 0x100 + ch * 4, then three control words.
  localparam logic [7:0] OFS_PINT_MODE = 8'h20;
  localparam logic [7:0] OFS_PINT_RISE = 8'h24;
  localparam logic [7:0] OFS_PINT_FALL = 8'h28;
  // Group area at 0x200, group g at g * 0x80.
  localparam logic [6:0] OFS_GRP_POL = 7'h00;
  localparam logic [6:0] OFS_GRP_ENA = 7'h20;
  localparam logic [6:0] OFS_GRP_CTRL = 7'h40;
  localparam int unsigned GRP_CTRL_AND = 0;
  localparam int unsigned GRP_CTRL_LEVEL = 1;
  // Interrupt status area at 0x300.
  localparam logic [7:0] OFS_IRQ_STAT = 8'h00;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN = 8'h08;

  // --------------------
  // Reset values
  // --------------------
  localparam logic [PW-1:0] DIR_RST = 31'h0000_0000;
  localparam logic [PW-1:0] PULL_RST = 31'h7FFF_FFFF;
  localparam logic [PW-1:0] MASK_RST = 31'h7FFF_FFFF;
  localparam logic [PW-1:0] OUT_RST = 31'h0000_0000;

  // --------------------
  // Types
  // --------------------
  typedef struct packed {
    logic [2:0] port;
    logic [4:0] pin;
  } gpx_pint_sel_t;

  typedef struct packed {
    logic [NPORT-1:0][PW-1:0] pol;
    logic [NPORT-1:0][PW-1:0] ena;
    logic and_mode;
    logic level_mode;
  } gpx_grp_cfg_t;

endpackage : gpx_pkg

`default_nettype wire

// File: gpx_gpio.sv
// Multi-port GPIO with pin and group interrupts behind an Avalon-MM slave.
//
// Summary of operation
// [RULE1] Eight ports, each with 31 pin bits.
// [RULE2] Free pins driven and sampled by these registers.
// [RULE3] Per-bit direction, input or output.
// [RULE4] Set and clear registers change chosen bits.
// [RULE5] Reads give output latch and live pins.
// [RULE6] Reset makes every pin input, pull-up on.
// [RULE7] Mask limits masked reads and writes.
// [RULE8] Byte, half-word and word accesses all work.
// [RULE9] One word write sets whole port output.
// [RULE10] Eight selectable pin interrupts, edge or level.
// [RULE11] Two group interrupts on selected pin conditions.
// [RULE12] Zero bits in set or clear change nothing.
// [RULE13] Only output-direction pins are driven.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`default_nettype none

module gpx_gpio #(
  parameter int unsigned NPORT = gpx_pkg::NPORT,
  parameter int unsigned PW = gpx_pkg::PW
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [gpx_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_in,
  output logic [NPORT-1:0][PW-1:0] pin_out,
  output logic [NPORT-1:0][PW-1:0] pin_oe_out,
  output logic [NPORT-1:0][PW-1:0] pin_pull_en_out,
  output logic irq_out
);

  // --------------------
  // Bus slave
  // --------------------
  // Every access takes one wait cycle: the answer is registered, which keeps the
  // wide read mux off the bus timing path at 250 MHz.
  logic ack_q;
  logic req;
  logic wr_go;
  logic [31:0] bm;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic [1:0] area;
  logic [2:0] port_idx;
  logic [4:0] port_ofs;

  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_go = avs_write_in & ack_q;
  assign avs_readdata_out = rdata_q;
  assign area = avs_address_in[9:8];
  assign port_idx = avs_address_in[7:5];
  assign port_ofs = {avs_address_in[4:2], 2'b00};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      bm[8*i +: 8] = {8{avs_byteenable_in[i]}}; // [RULE8]
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
    end
  end

  // --------------------
  // Port registers
  // --------------------
  logic [NPORT-1:0][PW-1:0] dir_q;
  logic [NPORT-1:0][PW-1:0] mask_q;
  logic [NPORT-1:0][PW-1:0] out_q;
  logic [NPORT-1:0][PW-1:0] pull_q;
  logic [NPORT-1:0][PW-1:0] pin_q;
  logic [NPORT-1:0][PW-1:0] pin_prev_q;

  // Pins are synchronous to the clock; one stage aligns them with the bus reads.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      // Reset to the pulled-up idle level, so no false edge follows reset.
      pin_q <= {NPORT{gpx_pkg::PULL_RST}};
      pin_prev_q <= {NPORT{gpx_pkg::PULL_RST}};
    end
    else
    begin
      pin_q <= pin_in; // [RULE2]
      pin_prev_q <= pin_q;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) // [RULE1]
    begin : g_port
      logic sel;
      logic [PW-1:0] wd;
      logic [PW-1:0] wm;

      assign sel = wr_go && (area == gpx_pkg::AREA_PORT) && (port_idx == 3'(gp));
      assign wd = avs_writedata_in[PW-1:0];
      assign wm = bm[PW-1:0];

      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          dir_q[gp] <= gpx_pkg::DIR_RST; // [RULE6]
          pull_q[gp] <= gpx_pkg::PULL_RST; // [RULE6]
        end
        else if (sel && port_ofs == gpx_pkg::OFS_DIR)
        begin
          dir_q[gp] <= (dir_q[gp] & ~wm) | (wd & wm); // [RULE3]
        end
        else if (sel && port_ofs == gpx_pkg::OFS_PULL)
        begin
          pull_q[gp] <= (pull_q[gp] & ~wm) | (wd & wm);
        end
      end

      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          mask_q[gp] <= gpx_pkg::MASK_RST;
        end
        else if (sel && port_ofs == gpx_pkg::OFS_MASK)
        begin
          mask_q[gp] <= (mask_q[gp] & ~wm) | (wd & wm);
        end
      end

      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          out_q[gp] <= gpx_pkg::OUT_RST;
        end
        else if (sel)
        begin
          unique case (port_ofs)
            gpx_pkg::OFS_OUT:
              out_q[gp] <= (out_q[gp] & ~wm) | (wd & wm); // [RULE9] [RULE8]
            gpx_pkg::OFS_MPIN:
              out_q[gp] <= (out_q[gp] & ~(wm & mask_q[gp])) | (wd & wm & mask_q[gp]); // [RULE7]
            gpx_pkg::OFS_SET:
              out_q[gp] <= out_q[gp] | (wd & wm); // [RULE4] [RULE12]
            gpx_pkg::OFS_CLR:
              out_q[gp] <= out_q[gp] & ~(wd & wm); // [RULE4] [RULE12]
            default:
              out_q[gp] <= out_q[gp];
          endcase
        end
      end
    end
  endgenerate

  // The latch reaches the pad always; the enable alone decides whether it drives.
  assign pin_out = out_q;
  assign pin_oe_out = dir_q; // [RULE13]
  assign pin_pull_en_out = pull_q;

  // --------------------
  // Pin interrupts
  // --------------------
  gpx_pkg::gpx_pint_sel_t [gpx_pkg::NPINT-1:0] pint_sel_q;
  logic [gpx_pkg::NPINT-1:0] pint_mode_q;
  logic [gpx_pkg::NPINT-1:0] pint_rise_q;
  logic [gpx_pkg::NPINT-1:0] pint_fall_q;
  logic [gpx_pkg::NPINT-1:0] pint_ev;
  logic pint_area;

  assign pint_area = wr_go && (area == gpx_pkg::AREA_PINT);

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pint_mode_q <= '0;
      pint_rise_q <= '0;
      pint_fall_q <= '0;
    end
    else if (pint_area && avs_address_in[7:0] == gpx_pkg::OFS_PINT_MODE)
    begin
      pint_mode_q <= (pint_mode_q & ~bm[7:0]) | (avs_writedata_in[7:0] & bm[7:0]);
    end
    else if (pint_area && avs_address_in[7:0] == gpx_pkg::OFS_PINT_RISE)
    begin
      pint_rise_q <= (pint_rise_q & ~bm[7:0]) | (avs_writedata_in[7:0] & bm[7:0]);
    end
    else if (pint_area && avs_address_in[7:0] == gpx_pkg::OFS_PINT_FALL)
    begin
      pint_fall_q <= (pint_fall_q & ~bm[7:0]) | (avs_writedata_in[7:0] & bm[7:0]);
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < gpx_pkg::NPINT; gc++)
    begin : g_pint
      logic cur;
      logic prev;

      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          pint_sel_q[gc] <= '0;
        end
        else if (pint_area && avs_address_in[7:0] == 8'(gc * 4) && avs_byteenable_in[0])
        begin
          pint_sel_q[gc] <= avs_writedata_in[7:0]; // [RULE10]
        end
      end

      // A selector naming pin 31 reads as constant low: no edge ever, but a fall-enabled level channel fires.
      always_comb
      begin
        cur = 1'b0;
        prev = 1'b0;
        if (32'(pint_sel_q[gc].pin) < PW)
        begin
          cur = pin_q[pint_sel_q[gc].port][pint_sel_q[gc].pin];
          prev = pin_prev_q[pint_sel_q[gc].port][pint_sel_q[gc].pin];
        end
      end

      // Level mode: rise enable means active high, fall enable means active low.
      assign pint_ev[gc] = pint_mode_q[gc] ?
          ((pint_rise_q[gc] & cur) | (pint_fall_q[gc] & ~cur)) :
          ((pint_rise_q[gc] & cur & ~prev) | (pint_fall_q[gc] & ~cur & prev)); // [RULE10]
    end
  endgenerate

  // --------------------
  // Group interrupts
  // --------------------
  gpx_pkg::gpx_grp_cfg_t [gpx_pkg::NGRP-1:0] grp_q;
  logic [gpx_pkg::NGRP-1:0] grp_req;
  logic [gpx_pkg::NGRP-1:0] grp_req_q;
  logic [gpx_pkg::NGRP-1:0] grp_ev;

  genvar gg;
  generate
    for (gg = 0; gg < gpx_pkg::NGRP; gg++)
    begin : g_grp
      logic gsel;
      logic [6:0] gofs;
      logic any_hit;
      logic all_hit;
      logic any_en;

      assign gsel = wr_go && (area == gpx_pkg::AREA_GRP) && (avs_address_in[7] == 1'(gg));
      assign gofs = avs_address_in[6:0];

      always_ff @(posedge core_clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
        begin
          grp_q[gg] <= '0;
        end
        else if (gsel)
        begin
          for (int p = 0; p < NPORT; p++)
          begin
            if (gofs == gpx_pkg::OFS_GRP_POL + 7'(p * 4))
            begin
              grp_q[gg].pol[p] <= (grp_q[gg].pol[p] & ~bm[PW-1:0]) |
                                  (avs_writedata_in[PW-1:0] & bm[PW-1:0]);
            end
            if (gofs == gpx_pkg::OFS_GRP_ENA + 7'(p * 4))
            begin
              grp_q[gg].ena[p] <= (grp_q[gg].ena[p] & ~bm[PW-1:0]) |
                                  (avs_writedata_in[PW-1:0] & bm[PW-1:0]);
            end
          end
          if (gofs == gpx_pkg::OFS_GRP_CTRL && avs_byteenable_in[0])
          begin
            grp_q[gg].and_mode <= avs_writedata_in[gpx_pkg::GRP_CTRL_AND];
            grp_q[gg].level_mode <= avs_writedata_in[gpx_pkg::GRP_CTRL_LEVEL];
          end
        end
      end

      // A pin matches when its level equals its polarity bit; an AND group
      // with nothing enabled stays quiet rather than firing forever.
      always_comb
      begin
        any_hit = 1'b0;
        all_hit = 1'b1;
        any_en = 1'b0;
        for (int p = 0; p < NPORT; p++)
        begin
          any_hit = any_hit | (|(grp_q[gg].ena[p] & ~(pin_q[p] ^ grp_q[gg].pol[p])));
          all_hit = all_hit & (&(~grp_q[gg].ena[p] | ~(pin_q[p] ^ grp_q[gg].pol[p])));
          any_en = any_en | (|grp_q[gg].ena[p]);
        end
      end

      assign grp_req[gg] = grp_q[gg].and_mode ? (all_hit & any_en) : any_hit; // [RULE11]
      assign grp_ev[gg] = grp_q[gg].level_mode ? grp_req[gg] :
                          (grp_req[gg] & ~grp_req_q[gg]); // [RULE11]
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      grp_req_q <= '0;
    end
    else
    begin
      grp_req_q <= grp_req;
    end
  end

  // --------------------
  // Interrupt status, clear and enable
  // --------------------
  logic [gpx_pkg::NIRQ-1:0] stat_q;
  logic [gpx_pkg::NIRQ-1:0] irq_en_q;
  logic [gpx_pkg::NIRQ-1:0] stat_clr;
  logic irq_area;
  logic irq_q;

  assign irq_area = wr_go && (area == gpx_pkg::AREA_IRQ);
  assign stat_clr = (irq_area && avs_address_in[7:0] == gpx_pkg::OFS_IRQ_CLR) ?
                    (avs_writedata_in[gpx_pkg::NIRQ-1:0] & bm[gpx_pkg::NIRQ-1:0]) : '0;

  // An event in the same cycle as its clear wins, so none is lost.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      stat_q <= '0;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | {grp_ev, pint_ev};
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_en_q <= '0;
    end
    else if (irq_area && avs_address_in[7:0] == gpx_pkg::OFS_IRQ_EN)
    begin
      irq_en_q <= (irq_en_q & ~bm[gpx_pkg::NIRQ-1:0]) |
                  (avs_writedata_in[gpx_pkg::NIRQ-1:0] & bm[gpx_pkg::NIRQ-1:0]);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(stat_q & irq_en_q);
    end
  end

  assign irq_out = irq_q;

  // --------------------
  // Read mux
  // --------------------
  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (area)
      gpx_pkg::AREA_PORT:
      begin
        unique case (port_ofs)
          gpx_pkg::OFS_DIR: rd_d = {1'b0, dir_q[port_idx]};
          gpx_pkg::OFS_MASK: rd_d = {1'b0, mask_q[port_idx]};
          gpx_pkg::OFS_PIN: rd_d = {1'b0, pin_q[port_idx]}; // [RULE5]
          gpx_pkg::OFS_MPIN: rd_d = {1'b0, pin_q[port_idx] & mask_q[port_idx]}; // [RULE7]
          gpx_pkg::OFS_SET: rd_d = {1'b0, out_q[port_idx]};
          gpx_pkg::OFS_PULL: rd_d = {1'b0, pull_q[port_idx]};
          gpx_pkg::OFS_OUT: rd_d = {1'b0, out_q[port_idx]}; // [RULE5]
          default: rd_d = 32'h0000_0000;
        endcase
      end
      gpx_pkg::AREA_PINT:
      begin
        if (avs_address_in[7:5] == 3'h0)
        begin
          rd_d = {24'h00_0000, pint_sel_q[avs_address_in[4:2]]};
        end
        else if (avs_address_in[7:0] == gpx_pkg::OFS_PINT_MODE)
        begin
          rd_d = {24'h00_0000, pint_mode_q};
        end
        else if (avs_address_in[7:0] == gpx_pkg::OFS_PINT_RISE)
        begin
          rd_d = {24'h00_0000, pint_rise_q};
        end
        else if (avs_address_in[7:0] == gpx_pkg::OFS_PINT_FALL)
        begin
          rd_d = {24'h00_0000, pint_fall_q};
        end
      end
      gpx_pkg::AREA_GRP:
      begin
        if (avs_address_in[6:5] == 2'h0)
        begin
          rd_d = {1'b0, grp_q[avs_address_in[7]].pol[avs_address_in[4:2]]};
        end
        else if (avs_address_in[6:5] == 2'h1)
        begin
          rd_d = {1'b0, grp_q[avs_address_in[7]].ena[avs_address_in[4:2]]};
        end
        else if (avs_address_in[6:0] == gpx_pkg::OFS_GRP_CTRL)
        begin
          rd_d = {30'h0000_0000, grp_q[avs_address_in[7]].level_mode,
                  grp_q[avs_address_in[7]].and_mode};
        end
      end
      gpx_pkg::AREA_IRQ:
      begin
        if (avs_address_in[7:0] == gpx_pkg::OFS_IRQ_STAT)
        begin
          rd_d = {22'h00_0000, stat_q};
        end
        else if (avs_address_in[7:0] == gpx_pkg::OFS_IRQ_EN)
        begin
          rd_d = {22'h00_0000, irq_en_q};
        end
      end
    endcase
  end

  // Read data is captured on the edge that raises the ack and held until the next read.
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (avs_read_in && !ack_q)
    begin
      rdata_q <= rd_d;
    end
  end

endmodule : gpx_gpio

`default_nettype wire

// File: gpx_gpio_asserts.sv
// Concurrent checks on the ports of the multi-port GPIO block.
`default_nettype none

module gpx_gpio_chk #(
  parameter int unsigned NPORT = 8,
  parameter int unsigned PW = 31
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_oe_out,
  input wire logic [NPORT-1:0][PW-1:0] pin_pull_en_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  wire req = avs_read_in || avs_write_in;
  // Only full-word port writes are tracked, so byte-lane effects do not muddle the check.
  wire taken = avs_write_in && !avs_waitrequest_out && avs_byteenable_in == 4'hF
    && avs_address_in[9:8] == gpx_pkg::AREA_PORT;
  logic [2:0] wp_q;
  logic [PW-1:0] wd_q;
  logic [PW-1:0] prev_q;

  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wp_q <= '0;
      wd_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      wp_q <= avs_address_in[7:5];
      wd_q <= avs_writedata_in[PW-1:0];
      prev_q <= pin_out[avs_address_in[7:5]];
    end
  end

  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("New request was not held for a wait cycle.");
  chk_wait_one: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("Request waited more than one cycle.");
  chk_idle_nowait: assert property (!req |-> !avs_waitrequest_out)
    else $error("Waitrequest high with no request.");
  chk_reset_state: assert property ($rose(resetn_in) |-> pin_oe_out == '0
    && pin_pull_en_out == '1 && !irq_out)
    else $error("Pins not all inputs with pull-ups after reset.");
  chk_dir_cause: assert property (!$stable(pin_oe_out) |-> $past(avs_write_in))
    else $error("Drive enables changed without a write.");
  chk_out_cause: assert property (!$stable(pin_out) |-> $past(avs_write_in))
    else $error("Output latch changed without a write.");
  chk_read_hold: assert property (!$stable(avs_readdata_out) |-> $past(avs_read_in))
    else $error("Read data moved without a read.");
  chk_irq_falls: assert property ($fell(irq_out)
    |-> $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("Interrupt dropped without a clear or mask write.");
  chk_set_bits: assert property (taken && avs_address_in[4:0] == gpx_pkg::OFS_SET
    |=> pin_out[wp_q] == (prev_q | wd_q))
    else $error("Set write did not set exactly the chosen bits.");
  chk_clr_bits: assert property (taken && avs_address_in[4:0] == gpx_pkg::OFS_CLR
    |=> pin_out[wp_q] == (prev_q & ~wd_q))
    else $error("Clear write did not clear exactly the chosen bits.");

  cov_set_write: cover property (taken && avs_address_in[4:0] == gpx_pkg::OFS_SET);
  cov_irq_rise: cover property ($rose(irq_out));
  cov_dir_change: cover property (!$stable(pin_oe_out));
endmodule : gpx_gpio_chk

bind gpx_gpio gpx_gpio_chk #(.NPORT(NPORT), .PW(PW)) u_chk (
  .core_clk_in(core_clk_in),
  .resetn_in(resetn_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .pin_out(pin_out),
  .pin_oe_out(pin_oe_out),
  .pin_pull_en_out(pin_pull_en_out),
  .irq_out(irq_out)
);

`default_nettype wire

// File: gpx_board.sv
// Board model: resolves each pin from the block's drive, the outside source and the pull-up.
`default_nettype none

module gpx_board #(
  parameter int unsigned NP = 8,
  parameter int unsigned W = 31
) (
  input wire logic [NP-1:0][W-1:0] drv_in,
  input wire logic [NP-1:0][W-1:0] oe_in,
  input wire logic [NP-1:0][W-1:0] pull_in,
  input wire logic [NP-1:0][W-1:0] ext_val_in,
  input wire logic [NP-1:0][W-1:0] ext_en_in,
  output logic [NP-1:0][W-1:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven pin without its pull-up sits on the board's weak pull-down, never floats.
  assign level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in)
    | (~oe_in & ~ext_en_in & pull_in);
endmodule : gpx_board

`default_nettype wire

// File: gpx_gpio_tb_top.sv
// Self-checking testbench of the multi-port GPIO block.
`default_nettype none

module gpx_gpio_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NP = gpx_pkg::NPORT;
  localparam int unsigned W = gpx_pkg::PW;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [gpx_pkg::ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] ben = '0;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic [NP-1:0][W-1:0] lvl, pout, poe, ppull;
  logic [NP-1:0][W-1:0] ext_val = '0;
  logic [NP-1:0][W-1:0] ext_en = '0;
  int bad_count = 0;
  int tests_run = 0;

  always #2 clk = ~clk;

  gpx_gpio i_dut (.core_clk_in(clk), .resetn_in(resetn), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(ben), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .pin_in(lvl), .pin_out(pout), .pin_oe_out(poe), .pin_pull_en_out(ppull), .irq_out(irq));
  gpx_board #(.NP(NP), .W(W)) i_board (.drv_in(pout), .oe_in(poe), .pull_in(ppull),
    .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(lvl));

  // --------------------
  // Bus and compare helpers
  // --------------------
  task automatic finish_test();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd_en <= !we;
    wr_en <= we;
    addr <= a;
    wdata <= d;
    ben <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0)
    begin
      bad_count++;
      $display("[ERR] waitrequest expected 0 seen stuck");
      finish_test();
    end
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr

  task automatic rdc(input string what, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
    chk(what, exp, q);
  endtask : rdc

  function automatic logic [9:0] pa(input int p, input logic [4:0] o);
    return 10'(p * 32) + 10'(o);
  endfunction : pa

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    chk("oe", 32'h0000_0000, {1'b0, poe[7]});
    chk("pull", 32'h7FFF_FFFF, {1'b0, ppull[0]});
    rdc("dir", pa(7, gpx_pkg::OFS_DIR), 32'h0000_0000);
    rdc("pullreg", pa(0, gpx_pkg::OFS_PULL), 32'h7FFF_FFFF);
    rdc("pin", pa(7, gpx_pkg::OFS_PIN), 32'h7FFF_FFFF);
    wr(10'h3FC, 32'hFFFF_FFFF);
    rdc("unmapped", 10'h3FC, 32'h0000_0000);
    $display("end of reset test");
  endtask : t_reset

  task automatic t_ports();
    for (int p = 0; p < 8; p++)
      wr(pa(p, gpx_pkg::OFS_OUT), 32'hF234_5670 + 32'(p));
    for (int p = 0; p < 8; p++)
      rdc("out", pa(p, gpx_pkg::OFS_OUT), 32'h7234_5670 + 32'(p));
    wr(pa(3, gpx_pkg::OFS_DIR), 32'h0000_FFFF);
    wr(pa(3, gpx_pkg::OFS_OUT), 32'h0000_A5A5);
    chk("oe3", 32'h0000_FFFF, {1'b0, poe[3]});
    rdc("pin3", pa(3, gpx_pkg::OFS_PIN), 32'h7FFF_A5A5);
    $display("end of port test");
  endtask : t_ports

  task automatic t_setclr();
    wr(pa(3, gpx_pkg::OFS_SET), 32'h0001_0F00);
    rdc("set", pa(3, gpx_pkg::OFS_SET), 32'h0001_AFA5);
    wr(pa(3, gpx_pkg::OFS_CLR), 32'h0000_00A0);
    rdc("clr", pa(3, gpx_pkg::OFS_OUT), 32'h0001_AF05);
    rdc("clrread", pa(3, gpx_pkg::OFS_CLR), 32'h0000_0000);
    $display("end of set clear test");
  endtask : t_setclr

  task automatic t_live();
    wr(pa(5, gpx_pkg::OFS_PULL), 32'h0000_0000);
    @(posedge clk);
    ext_en[5] <= '1;
    ext_val[5] <= 31'h2AAA_5555;
    repeat (2) @(posedge clk);
    rdc("live", pa(5, gpx_pkg::OFS_PIN), 32'h2AAA_5555);
    rdc("latch", pa(5, gpx_pkg::OFS_OUT), 32'h7234_5675);
    $display("end of live pin test");
  endtask : t_live

  task automatic t_mask();
    wr(pa(2, gpx_pkg::OFS_OUT), 32'h0000_0000);
    wr(pa(2, gpx_pkg::OFS_MASK), 32'h0000_00FF);
    wr(pa(2, gpx_pkg::OFS_MPIN), 32'hFFFF_FFFF);
    rdc("mout", pa(2, gpx_pkg::OFS_OUT), 32'h0000_00FF);
    rdc("mpin", pa(2, gpx_pkg::OFS_MPIN), 32'h0000_00FF);
    $display("end of mask test");
  endtask : t_mask

  task automatic t_bytes();
    logic [31:0] q;
    bus(1'b1, pa(6, gpx_pkg::OFS_OUT), 32'hDEAD_BEEF, 4'b0100, q);
    rdc("lane2", pa(6, gpx_pkg::OFS_OUT), 32'h72AD_5676);
    bus(1'b1, pa(6, gpx_pkg::OFS_OUT), 32'h1111_2222, 4'b0011, q);
    bus(1'b1, pa(6, gpx_pkg::OFS_OUT), 32'h8000_0000, 4'b1000, q);
    rdc("half", pa(6, gpx_pkg::OFS_OUT), 32'h00AD_2222);
    $display("end of byte lane test");
  endtask : t_bytes

  task automatic t_pint();
    @(posedge clk);
    ext_en[1][4] <= 1'b1;
    wr(10'h100, 32'h0000_0024);
    wr(10'h124, 32'h0000_0001);
    wr(10'h308, 32'h0000_0001);
    ext_val[1][4] <= 1'b1;
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("stat", 10'h300, 32'h0000_0001);
    wr(10'h304, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irqclr", 32'h0, {31'h0, irq});
    wr(10'h104, 32'h0000_0024);
    wr(10'h120, 32'h0000_0002);
    wr(10'h128, 32'h0000_0002);
    wr(10'h308, 32'h0000_0003);
    ext_val[1][4] <= 1'b0;
    repeat (4) @(posedge clk);
    wr(10'h304, 32'h0000_0002);
    rdc("level", 10'h300, 32'h0000_0002);
    wr(10'h308, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("irqmask", 32'h0, {31'h0, irq});
    ext_val[1][4] <= 1'b1;
    wr(10'h304, 32'h0000_03FF);
    $display("end of pin interrupt test");
  endtask : t_pint

  task automatic t_group();
    @(posedge clk);
    ext_en[4] <= 31'h0000_0007;
    ext_val[4] <= 31'h0000_0001;
    wr(10'h210, 32'h0000_0003);
    wr(10'h240, 32'h0000_0001);
    wr(10'h230, 32'h0000_0003);
    wr(10'h308, 32'h0000_0300);
    rdc("and0", 10'h300, 32'h0000_0000);
    ext_val[4] <= 31'h0000_0003;
    repeat (4) @(posedge clk);
    rdc("and1", 10'h300, 32'h0000_0100);
    wr(10'h2B0, 32'h0000_0004);
    wr(10'h2C0, 32'h0000_0002);
    repeat (4) @(posedge clk);
    rdc("orlvl", 10'h300, 32'h0000_0300);
    chk("girq", 32'h1, {31'h0, irq});
    $display("end of group interrupt test");
  endtask : t_group

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ports();
    t_setclr();
    t_live();
    t_mask();
    t_bytes();
    t_pint();
    t_group();
    finish_test();
  end
endmodule : gpx_gpio_tb_top

`default_nettype wire
